// *** ext_sfr_bank.sv ***
/*
  Extended peripheral register bank: address decode, width checks, storage and read-back.
  Assumes the core issues at most one request per clock on the same clock, and that
  peripheral logic drives the read-only values on the same clock.
*/
// How it works
// RL1 - Decode F0000H to F07FFH, all registers inside
// RL2 - Ordinary register range never decoded here
// RL3 - Core encodes extended accesses one byte longer
// RL4 - Each register accepts only its width set
// RL5 - Word access uses even address, pair bytes
// RL6 - Registers load tabulated values on reset
// RL7 - Read-only registers ignore writes
// RL8 - Software avoids unassigned extended addresses
// RL9 - Serial status: read-only, word or low byte
// RL10 - Port registers: bit and byte, reset zero
// RL11 - Analog select and trim: byte only, 10H
// RL12 - Decimal result: read-only byte, undefined reset
// RL13 - Serial output, mode: word only, own resets
// RL14 - Bad width or address: no change, zero
`timescale 1ns/1ps
`include "ext_sfr_regs.svh"

module ext_sfr_bank
  import ext_sfr_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire req_t                    req_i,
  input  wire logic [NUM_RO-1:0][15:0] ro_val_i,
  output logic      [NUM_RW-1:0][15:0] ctrl_o,
  output logic      [15:0]             rdata_o,
  output logic                         ack_o,
  output logic                         err_o
);

  // ****************************************
  // Register tables
  // ****************************************
  localparam reg_desc_t RW_TBL [NUM_RW] = '{
    '{`OFF_ANALOG_PIN_SELECT,     `RST_ANALOG_PIN, `ACC_BYTE},      // RL11
    '{`OFF_PULLUP_SEL_PORT_A,     `RST_ZERO,       `ACC_BIT_BYTE},  // RL10
    '{`OFF_PULLUP_SEL_PORT_B,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_C,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_D,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_E,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_F,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_G,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_H,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PULLUP_SEL_PORT_I,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_INPUT_LEVEL_PORT_A,    `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_INPUT_LEVEL_PORT_D,    `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_INPUT_LEVEL_PORT_I,    `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_OPEN_DRAIN_PORT_A,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_OPEN_DRAIN_PORT_D,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_OPEN_DRAIN_PORT_I,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_INPUT_FILTER_EN_A,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_INPUT_FILTER_EN_B,     `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_PERIPHERAL_CLOCK_GATE, `RST_ZERO,       `ACC_BIT_BYTE},
    '{`OFF_FAST_OSC_TRIM,         `RST_OSC_TRIM,   `ACC_BYTE},      // RL11
    '{`OFF_SPEED_MODE_CTRL,       `RST_ZERO,       `ACC_BYTE},
    '{`OFF_REGULATOR_MODE_CTRL,   `RST_ZERO,       `ACC_BYTE},
    '{`OFF_SER_FLAG_CLEAR_U0_CH0, `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_FLAG_CLEAR_U0_CH1, `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_FLAG_CLEAR_U0_CH2, `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_FLAG_CLEAR_U0_CH3, `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_MODE_U0_CH0,       `RST_SER_MODE,   `ACC_WORD},      // RL13
    '{`OFF_SER_MODE_U0_CH1,       `RST_SER_MODE,   `ACC_WORD},
    '{`OFF_SER_MODE_U0_CH2,       `RST_SER_MODE,   `ACC_WORD},
    '{`OFF_SER_MODE_U0_CH3,       `RST_SER_MODE,   `ACC_WORD},
    '{`OFF_SER_COMM_SETUP_U0_CH0, `RST_SER_SETUP,  `ACC_WORD},      // RL6
    '{`OFF_SER_COMM_SETUP_U0_CH1, `RST_SER_SETUP,  `ACC_WORD},
    '{`OFF_SER_COMM_SETUP_U0_CH2, `RST_SER_SETUP,  `ACC_WORD},
    '{`OFF_SER_COMM_SETUP_U0_CH3, `RST_SER_SETUP,  `ACC_WORD},
    '{`OFF_SER_UNIT0_START,       `RST_ZERO,       `ACC_ALL},
    '{`OFF_SER_UNIT0_HALT,        `RST_ZERO,       `ACC_ALL},
    '{`OFF_SER_UNIT0_PRESCALE,    `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_UNIT0_OUT_VALUE,   `RST_SER_OUT,    `ACC_WORD},      // RL13
    '{`OFF_SER_UNIT0_OUT_ENABLE,  `RST_ZERO,       `ACC_ALL},
    '{`OFF_SER_UNIT0_OUT_INVERT,  `RST_ZERO,       `ACC_BYTE_WORD}
  };

  // Read-only entries carry no reset: their value is the peripheral's live state
  localparam reg_desc_t RO_TBL [NUM_RO] = '{
    '{`OFF_DECIMAL_FIXUP_RESULT,  `RST_ZERO,       `ACC_BYTE},      // RL12
    '{`OFF_SER_STATUS_U0_CH0,     `RST_ZERO,       `ACC_BYTE_WORD}, // RL9
    '{`OFF_SER_STATUS_U0_CH1,     `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_STATUS_U0_CH2,     `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_STATUS_U0_CH3,     `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_UNIT0_RUNNING,     `RST_ZERO,       `ACC_ALL},
    '{`OFF_SER_STATUS_U1_CH0,     `RST_ZERO,       `ACC_BYTE_WORD},
    '{`OFF_SER_STATUS_U1_CH1,     `RST_ZERO,       `ACC_BYTE_WORD}
  };

  // ****************************************
  // Helpers
  // ****************************************
  function automatic word_t shape_read(input word_t v, input access_size_t sz, input logic [2:0] b);
    word_t r;
    r = 16'h0000;
    case (sz)
      SIZE_BIT:  r = {15'h0000, v[b]};
      SIZE_BYTE: r = {8'h00, v[7:0]};
      SIZE_WORD: r = v;
      default:   r = 16'h0000;
    endcase
    return r;
  endfunction

  function automatic word_t merge_write(input word_t v, input req_t q);
    word_t r;
    r = v;
    case (q.size)
      SIZE_BIT:  r[q.bit_sel] = q.wdata[0];
      SIZE_BYTE: r[7:0] = q.wdata[7:0];
      SIZE_WORD: r = q.wdata;
      default:   r = v;
    endcase
    return r;
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  wire logic             in_area;
  wire logic [2:0]       size_mask;
  wire logic             area_req;
  wire logic             is_read;
  logic [NUM_RW-1:0]     rw_sel;
  logic [NUM_RO-1:0]     ro_sel;
  word_t                 rw_reg [NUM_RW];
  word_t                 rw_rd  [NUM_RW];
  word_t                 ro_rd  [NUM_RO];
  word_t                 rdata_next;
  logic                  hit_any;

  // Ordinary area lies above the extended one, so it never decodes here
  assign in_area   = (req_i.addr >= `EXT_AREA_LO) && (req_i.addr <= `EXT_AREA_HI); // RL1 RL2
  assign area_req  = req_i.valid & in_area;
  assign is_read   = ~req_i.write;
  assign size_mask = (req_i.size == SIZE_BIT)  ? 3'h1 :
                     (req_i.size == SIZE_BYTE) ? 3'h2 :
                     (req_i.size == SIZE_WORD) ? 3'h4 : 3'h0;

  // ****************************************
  // Storage
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++) begin : g_rw
      // Word entries sit on even addresses, so odd word requests never match
      assign rw_sel[gi] = area_req && (req_i.addr == RW_TBL[gi].addr) &&
                          ((RW_TBL[gi].allow & size_mask) != 3'h0); // RL4 RL5
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          rw_reg[gi] <= RW_TBL[gi].rst; // RL6
        end else if (rw_sel[gi] && req_i.write) begin
          rw_reg[gi] <= merge_write(rw_reg[gi], req_i);
        end
      end
      assign rw_rd[gi]  = (rw_sel[gi] && is_read) ? shape_read(rw_reg[gi], req_i.size, req_i.bit_sel) : 16'h0000;
      assign ctrl_o[gi] = rw_reg[gi];
    end
    for (gi = 0; gi < NUM_RO; gi++) begin : g_ro
      assign ro_sel[gi] = area_req && (req_i.addr == RO_TBL[gi].addr) &&
                          ((RO_TBL[gi].allow & size_mask) != 3'h0); // RL9 RL12
      // Write hits nothing: live value from the peripheral
      assign ro_rd[gi]  = (ro_sel[gi] && is_read) ? shape_read(ro_val_i[gi], req_i.size, req_i.bit_sel) : 16'h0000; // RL7
    end
  endgenerate

  // ****************************************
  // Read-back
  // ****************************************
  always_comb begin
    rdata_next = 16'h0000;
    for (int i = 0; i < NUM_RW; i++) begin
      rdata_next = rdata_next | rw_rd[i];
    end
    for (int i = 0; i < NUM_RO; i++) begin
      rdata_next = rdata_next | ro_rd[i];
    end
  end

  // Read-only hit on a write is still a refusal
  assign hit_any = (|rw_sel) | ((|ro_sel) & is_read); // RL7 RL14

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      rdata_o <= rdata_next; // RL14
      ack_o   <= area_req;
      err_o   <= area_req & ~hit_any; // RL8 RL14
    end
  end

endmodule

// *** ext_sfr_regs.svh ***
/*
  Addresses, access-width codes and reset values for the extended peripheral register bank.
  Assumes it is included by bare name into the bank module only.
*/
`ifndef EXT_SFR_REGS_SVH
`define EXT_SFR_REGS_SVH

// ****************************************
// Area bounds
// ****************************************
`define EXT_AREA_LO                20'hF0000
`define EXT_AREA_HI                20'hF07FF
`define ORD_AREA_LO                20'hFFF00
`define ORD_AREA_HI                20'hFFFFF

// ****************************************
// Access width sets: bit 0 single bit, bit 1 byte, bit 2 word
// ****************************************
`define ACC_BYTE                   3'h2
`define ACC_BIT_BYTE               3'h3
`define ACC_WORD                   3'h4
`define ACC_BYTE_WORD              3'h6
`define ACC_ALL                    3'h7

// ****************************************
// Reset values
// ****************************************
`define RST_ZERO                   16'h0000
`define RST_ANALOG_PIN             16'h0010
`define RST_OSC_TRIM               16'h0010
`define RST_SER_MODE               16'h0020
`define RST_SER_SETUP              16'h0087
`define RST_SER_OUT                16'h0F0F

// ****************************************
// Read/write register addresses
// ****************************************
`define OFF_ANALOG_PIN_SELECT      20'hF0017
`define OFF_PULLUP_SEL_PORT_A      20'hF0030
`define OFF_PULLUP_SEL_PORT_B      20'hF0031
`define OFF_PULLUP_SEL_PORT_C      20'hF0033
`define OFF_PULLUP_SEL_PORT_D      20'hF0034
`define OFF_PULLUP_SEL_PORT_E      20'hF0035
`define OFF_PULLUP_SEL_PORT_F      20'hF0037
`define OFF_PULLUP_SEL_PORT_G      20'hF0039
`define OFF_PULLUP_SEL_PORT_H      20'hF003C
`define OFF_PULLUP_SEL_PORT_I      20'hF003E
`define OFF_INPUT_LEVEL_PORT_A     20'hF0040
`define OFF_INPUT_LEVEL_PORT_D     20'hF0044
`define OFF_INPUT_LEVEL_PORT_I     20'hF004E
`define OFF_OPEN_DRAIN_PORT_A      20'hF0050
`define OFF_OPEN_DRAIN_PORT_D      20'hF0054
`define OFF_OPEN_DRAIN_PORT_I      20'hF005E
`define OFF_INPUT_FILTER_EN_A      20'hF0060
`define OFF_INPUT_FILTER_EN_B      20'hF0061
`define OFF_PERIPHERAL_CLOCK_GATE  20'hF00F0
`define OFF_FAST_OSC_TRIM          20'hF00F2
`define OFF_SPEED_MODE_CTRL        20'hF00F3
`define OFF_REGULATOR_MODE_CTRL    20'hF00F4
`define OFF_SER_FLAG_CLEAR_U0_CH0  20'hF0108
`define OFF_SER_FLAG_CLEAR_U0_CH1  20'hF010A
`define OFF_SER_FLAG_CLEAR_U0_CH2  20'hF010C
`define OFF_SER_FLAG_CLEAR_U0_CH3  20'hF010E
`define OFF_SER_MODE_U0_CH0        20'hF0110
`define OFF_SER_MODE_U0_CH1        20'hF0112
`define OFF_SER_MODE_U0_CH2        20'hF0114
`define OFF_SER_MODE_U0_CH3        20'hF0116
`define OFF_SER_COMM_SETUP_U0_CH0  20'hF0118
`define OFF_SER_COMM_SETUP_U0_CH1  20'hF011A
`define OFF_SER_COMM_SETUP_U0_CH2  20'hF011C
`define OFF_SER_COMM_SETUP_U0_CH3  20'hF011E
`define OFF_SER_UNIT0_START        20'hF0122
`define OFF_SER_UNIT0_HALT         20'hF0124
`define OFF_SER_UNIT0_PRESCALE     20'hF0126
`define OFF_SER_UNIT0_OUT_VALUE    20'hF0128
`define OFF_SER_UNIT0_OUT_ENABLE   20'hF012A
`define OFF_SER_UNIT0_OUT_INVERT   20'hF0134

// ****************************************
// Read-only register addresses
// ****************************************
`define OFF_DECIMAL_FIXUP_RESULT   20'hF00FE
`define OFF_SER_STATUS_U0_CH0      20'hF0100
`define OFF_SER_STATUS_U0_CH1      20'hF0102
`define OFF_SER_STATUS_U0_CH2      20'hF0104
`define OFF_SER_STATUS_U0_CH3      20'hF0106
`define OFF_SER_UNIT0_RUNNING      20'hF0120
`define OFF_SER_STATUS_U1_CH0      20'hF0140
`define OFF_SER_STATUS_U1_CH1      20'hF0142

`endif

// *** ext_sfr_pkg.sv ***
/*
  Types shared by the extended register bank and its users.
  Assumes nothing of its surroundings.
*/
package ext_sfr_pkg;

  localparam int NUM_RW = 40;
  localparam int NUM_RO = 8;

  typedef logic [15:0] word_t;

  typedef enum logic [1:0] {
    SIZE_BIT,
    SIZE_BYTE,
    SIZE_WORD
  } access_size_t;

  typedef struct packed {
    logic         valid;
    logic         write;
    access_size_t size;
    logic [2:0]   bit_sel;
    logic [19:0]  addr;
    word_t        wdata;
  } req_t;

  typedef struct packed {
    logic [19:0] addr;
    word_t       rst;
    logic [2:0]  allow;
  } reg_desc_t;

endpackage

// *** ext_sfr_bank_sva.sv ***
/*
  Checker for the extended register bank ports.
  Assumes the bind below attaches it to every bank instance.
*/
`timescale 1ns/1ps
module ext_sfr_bank_sva
  import ext_sfr_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire req_t                    req_i,
  input wire logic [NUM_RO-1:0][15:0] ro_val_i,
  input wire logic [NUM_RW-1:0][15:0] ctrl_o,
  input wire logic [15:0]             rdata_o,
  input wire logic                    ack_o,
  input wire logic                    err_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire in_area = req_i.valid && req_i.addr[19:11] == 9'h1E0;
  wire ro_hit  = req_i.addr inside {20'hF00FE, 20'hF0100, 20'hF0102, 20'hF0104, 20'hF0106, 20'hF0120,
                                    20'hF0140, 20'hF0142};
  sequence setup_wr_s;
    in_area && req_i.write && req_i.size == SIZE_WORD && req_i.addr == 20'hF0118;
  endsequence
  sequence ro_wr_s;
    in_area && req_i.write && ro_hit;
  endsequence
  ack_taken_a: assert property (in_area |=> ack_o)
    else $error("area request not acknowledged");
  ack_cause_a: assert property (ack_o |-> $past(in_area))
    else $error("acknowledge without request");
  outside_ack_a: assert property (req_i.valid && !in_area |=> !ack_o)
    else $error("outside address acknowledged");
  err_zero_a: assert property (err_o |-> ack_o && rdata_o == 16'h0000)
    else $error("refusal without ack or with data");
  odd_word_a: assert property (in_area && req_i.size == SIZE_WORD && req_i.addr[0] |=> err_o)
    else $error("odd word access accepted");
  word_only_a: assert property (in_area && req_i.size != SIZE_WORD && req_i.addr[19:4] == 16'hF011 |=> err_o)
    else $error("narrow access to word register accepted");
  ro_write_a: assert property (ro_wr_s |=> err_o && ctrl_o == $past(ctrl_o))
    else $error("read-only write not refused");
  setup_store_a: assert property (setup_wr_s |=> ctrl_o[30] == $past(req_i.wdata))
    else $error("setup word write lost");
  byte_read_a: assert property (in_area && !req_i.write && req_i.size == SIZE_BYTE && req_i.addr == 20'hF0030
    |=> !err_o && rdata_o == {8'h00, ctrl_o[1][7:0]})
    else $error("pull-up byte read wrong");
endmodule
bind ext_sfr_bank ext_sfr_bank_sva sva_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .ro_val_i(ro_val_i),
  .ctrl_o(ctrl_o), .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o));

// *** core_model.sv ***
/*
  Core stand-in issuing one register access per call.
  Assumes the bank answers one cycle after the taking edge.
*/
`timescale 1ns/1ps
module core_model
  import ext_sfr_pkg::*;
(
  input  wire logic        clk_i,
  output req_t             req_o,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [15:0] rdata_i
);
  // ****
  // Access task
  // ****
  initial req_o = '0;
  // Longer extended opcode only costs core time, invisible here
  task automatic access(input req_t r, output logic ack, output logic err, output logic [15:0] rd);
    @(posedge clk_i);
    req_o <= r;
    @(posedge clk_i);
    // Released fields flip so stale values cannot pass
    req_o <= req_t'({1'b0, ~r[41:0]});
    // Answer launched on the taking edge, read at the next one
    @(posedge clk_i);
    ack = ack_i;
    err = err_i;
    rd = rdata_i;
  endtask
endmodule

// *** ext_sfr_bank_test.sv ***
/*
  Random self-checking bench for the extended register bank.
  Assumes package, bank, checker and core_model compiled first.
*/
`timescale 1ns/1ps
module ext_sfr_bank_test
  import ext_sfr_pkg::*;
;
  // ****
  // Bench
  // ****
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  req_t                    req;
  logic [NUM_RO-1:0][15:0] ro_val = '0;
  logic [NUM_RW-1:0][15:0] ctrl;
  logic [15:0]             rdata, rd;
  logic                    ack_o, err_o, ack, err;
  int                      bad_count = 0;
  int                      n_checks = 0;
  int                      cycles = 0;
  logic [15:0]             mdl [48];
  localparam logic [7:0]  LO [22] = '{8'h17, 8'h30, 8'h31, 8'h33, 8'h34, 8'h35, 8'h37, 8'h39, 8'h3C, 8'h3E,
    8'h40, 8'h44, 8'h4E, 8'h50, 8'h54, 8'h5E, 8'h60, 8'h61, 8'hF0, 8'hF2, 8'hF3, 8'hF4};
  localparam logic [11:0] RO_A [8] = '{12'h0FE, 12'h100, 12'h102, 12'h104, 12'h106, 12'h120, 12'h140, 12'h142};
  localparam logic [19:0] SP_A [7] = '{20'hF0111, 20'hF0101, 20'hF0119, 20'hF07FF, 20'hF0800, 20'hFFF00,
    20'hEFFFF};
  always #10 clk_i = ~clk_i;
  ext_sfr_bank uut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .ro_val_i(ro_val), .ctrl_o(ctrl),
    .rdata_o(rdata), .ack_o(ack_o), .err_o(err_o));
  core_model core (.clk_i(clk_i), .req_o(req), .ack_i(ack_o), .err_i(err_o), .rdata_i(rdata));
  // Index 0..39 writable in ctrl_o order, 40..47 read-only
  function automatic logic [19:0] addr_of(int i);
    if (i < 22) return {12'hF00, LO[i]};
    if (i < 34) return 20'hF0108 + 20'(2 * (i - 22));
    if (i < 39) return 20'hF0122 + 20'(2 * (i - 34));
    if (i == 39) return 20'hF0134;
    return {8'hF0, RO_A[i - 40]};
  endfunction
  function automatic logic [2:0] allow_of(int i);
    if (i == 0 || i == 19 || i == 20 || i == 21 || i == 40) return 3'h2;
    if (i < 19) return 3'h3;
    if (i < 26 || i == 36 || i == 39 || i > 40 && i != 45) return 3'h6;
    if (i < 34 || i == 37) return 3'h4;
    return 3'h7;
  endfunction
  function automatic logic [15:0] rst_of(int i);
    if (i == 0 || i == 19) return 16'h0010;
    if (i > 25 && i < 30) return 16'h0020;
    if (i > 29 && i < 34) return 16'h0087;
    return i == 37 ? 16'h0F0F : 16'h0000;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic check_resets();
    for (int i = 0; i < 40; i++) chk("reset value", rst_of(i), ctrl[i]);
  endtask
  task automatic op(input int i, input int s, input logic w);
    logic [2:0]  b, al;
    logic [15:0] d, e;
    logic        ok;
    b = 3'($urandom);
    d = 16'($urandom);
    al = allow_of(i);
    ok = al[s] && !(w && i > 39);
    e = s == 0 ? {15'h0, mdl[i][b]} : s == 1 ? {8'h00, mdl[i][7:0]} : mdl[i];
    core.access('{1'b1, w, access_size_t'(s), b, addr_of(i), d}, ack, err, rd);
    if (ok && w && s == 0) mdl[i][b] = d[0];
    if (ok && w && s == 1) mdl[i][7:0] = d[7:0];
    if (ok && w && s == 2) mdl[i] = d;
    chk("ack", 16'h0001, {15'h0, ack});
    chk("err", {15'h0, !ok}, {15'h0, err});
    chk("rdata", ok && !w ? e : 16'h0000, rd);
    if (i < 40) chk("ctrl", mdl[i], ctrl[i]);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h2d20));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < NUM_RO; k++) ro_val[k] <= 16'($urandom);
    @(posedge clk_i);
    #1;
    check_resets();
    for (int i = 0; i < 48; i++) mdl[i] = i < 40 ? rst_of(i) : ro_val[i - 40];
    $display("reset test done");
    // Every size written then read per register, then random mix
    for (int i = 0; i < 48; i++) begin
      for (int j = 0; j < 10; j++) op(i, j < 6 ? j % 3 : $urandom_range(2), j < 3 || j > 5 && $urandom_range(1));
    end
    $display("width test done");
    for (int k = 0; k < 7; k++) begin
      core.access('{1'b1, 1'b1, k ? SIZE_BYTE : SIZE_WORD, 3'h0, SP_A[k], 16'($urandom)}, ack, err, rd);
      chk("edge ack", {15'h0, k < 4}, {15'h0, ack});
      chk("edge err", {15'h0, k < 4}, {15'h0, err});
    end
    for (int i = 0; i < 40; i++) chk("ctrl kept", mdl[i], ctrl[i]);
    $display("decode test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check_resets();
    $display("second reset test done");
    end_sim();
  end
endmodule
